// ---- verilog/wblm_pkg.sv ----
// Package: shared types and constants for the byte-lane load/store master
package wblm_pkg;

	localparam int unsigned DATA_W        = 32;
	localparam int unsigned ADDR_W        = 32;
	localparam int unsigned SEL_W         = 4;
	localparam int unsigned PERIPH_ADDR_W = 24;

	// Address map: peripheral window is the top 16 MB
	localparam logic [7:0]  PERIPH_TOP_BYTE = 8'hFF;
	localparam logic [31:0] MEM_BASE        = 32'h0100_0000;
	localparam logic [31:0] MEM_END         = 32'h8000_0000;

	// Acknowledge time-out in bus clock cycles
	localparam int unsigned ACK_TIMEOUT_CYC = 4096;
	localparam int unsigned TMO_W           = 13;

	// Operand sizes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	// Lane select patterns
	localparam logic [3:0] SEL_NONE = 4'h0;
	localparam logic [3:0] SEL_B0   = 4'h1;
	localparam logic [3:0] SEL_H0   = 4'h3;
	localparam logic [3:0] SEL_H1   = 4'hC;
	localparam logic [3:0] SEL_WORD = 4'hF;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [1:0]  size;
		logic        write;
		logic        signed_ld;
	} wblm_req_t;

	typedef struct packed {
		logic [31:0] rdata;
		logic        timeout;
		logic        misalign;
	} wblm_rsp_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  sel;
		logic        we;
		logic        stb;
		logic        cyc;
	} wblm_bus_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_BUSY = 3'h2,
		ST_DONE = 3'h4
	} wblm_state_t;

endpackage : wblm_pkg

// ---- verilog/wblm_lane_map.sv ----
// Lane mapper: store placement, lane selects and load extension
`timescale 1ns/1ps
module wblm_lane_map
(
	// Request side
	input  wire logic [1:0]  addr_lo,
	input  wire logic [1:0]  size,
	input  wire logic        signed_ld,
	input  wire logic [31:0] store_data,
	// Bus side
	input  wire logic [31:0] bus_rdata,
	output logic [3:0]       lane_sel,
	output logic [31:0]      lane_wdata,
	output logic [31:0]      load_data,
	output logic             misalign
);

	function automatic logic [3:0] sel_of(input logic [1:0] sz,
		input logic [1:0] lo);
		logic [3:0] s;
		s = wblm_pkg::SEL_NONE;
		if (sz == wblm_pkg::SIZE_BYTE)
			s = 4'(wblm_pkg::SEL_B0 << lo);
		else if (sz == wblm_pkg::SIZE_HALF)
			s = lo[1] ? wblm_pkg::SEL_H1 : wblm_pkg::SEL_H0;
		else if (sz == wblm_pkg::SIZE_WORD)
			s = wblm_pkg::SEL_WORD;
		return s;
	endfunction : sel_of

	wire logic [4:0]  shift_bits = {addr_lo, 3'h0};
	wire logic [31:0] rd_shift   = bus_rdata >> shift_bits;
	wire logic [7:0]  rd_byte    = rd_shift[7:0];
	wire logic [15:0] rd_half    = rd_shift[15:0];
	wire logic        fill_b     = signed_ld & rd_byte[7];
	wire logic        fill_h     = signed_ld & rd_half[15];

	assign misalign = (size == wblm_pkg::SIZE_WORD && addr_lo != 2'h0) ||
		(size == wblm_pkg::SIZE_HALF && addr_lo[0]);
	assign lane_sel = sel_of(size, addr_lo);
	// Word stores put byte n on lane n, little-endian; halves and bytes are replicated across all lanes
	assign lane_wdata = (size == wblm_pkg::SIZE_WORD) ? store_data :
		(size == wblm_pkg::SIZE_HALF) ? {2{store_data[15:0]}} :
		{4{store_data[7:0]}};
	assign load_data = (size == wblm_pkg::SIZE_BYTE) ?
		{{24{fill_b}}, rd_byte} :
		(size == wblm_pkg::SIZE_HALF) ?
		{{16{fill_h}}, rd_half} :
		bus_rdata;

endmodule : wblm_lane_map

// ---- verilog/wblm_timeout.sv ----
// Acknowledge watchdog: flags a stalled strobe after the time-out count
`timescale 1ns/1ps
module wblm_timeout
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Control
	input  wire logic run,
	output logic      expired
);

	localparam logic [12:0] LAST = 13'(wblm_pkg::ACK_TIMEOUT_CYC - 1);

	logic [12:0] cnt_q;
	logic [12:0] cnt_d;

	assign cnt_d   = run ? cnt_q + 13'h1 : 13'h0;
	assign expired = run && (cnt_q == LAST);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= 13'h0;
		else
			cnt_q <= cnt_d;
	end

endmodule : wblm_timeout

// ---- verilog/wblm_master.sv ----
// Top: byte-lane load/store path onto memory and peripheral masters
`timescale 1ns/1ps
module wblm_master
(
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	// Core request
	input  wire logic                req_valid,
	input  wire wblm_pkg::wblm_req_t req,
	output logic                     req_ready,
	// Core response
	output logic                     rsp_valid,
	output wblm_pkg::wblm_rsp_t      rsp,
	// External memory port
	output logic [31:0]              mem_addr_out,
	output logic [31:0]              mem_wdata_out,
	output logic [3:0]               mem_lane_sel_out,
	output logic                     mem_we_out,
	output logic                     mem_strobe_out,
	output logic                     mem_cycle_out,
	input  wire logic [31:0]         mem_rdata_in,
	input  wire logic                mem_ack_in,
	// Peripheral I/O port
	output logic [23:0]              periph_addr_out,
	output logic [31:0]              periph_wdata_out,
	output logic [3:0]               periph_lane_sel_out,
	output logic                     periph_we_out,
	output logic                     periph_strobe_out,
	output logic                     periph_cycle_out,
	input  wire logic [31:0]         periph_rdata_in,
	input  wire logic                periph_ack_in
);

	wblm_pkg::wblm_state_t state_q;
	wblm_pkg::wblm_state_t state_d;
	wblm_pkg::wblm_req_t   req_q;
	wblm_pkg::wblm_rsp_t   rsp_q;
	wblm_pkg::wblm_rsp_t   rsp_d;
	wblm_pkg::wblm_bus_t   mbus_q;
	wblm_pkg::wblm_bus_t   mbus_d;
	wblm_pkg::wblm_bus_t   pbus_q;
	wblm_pkg::wblm_bus_t   pbus_d;
	logic                  to_periph_q;
	logic                  rsp_valid_q;
	logic                  ready_q;

	// Lane mapping for the incoming request
	wire logic [3:0]  new_sel;
	wire logic [31:0] new_wdata;
	wire logic        new_misalign;
	// Lane mapping for the active transfer (load extension)
	wire logic [31:0] act_rdata;
	wire logic [31:0] act_load;

	wblm_lane_map u_req_map
	(
		.addr_lo    (req.addr[1:0]),
		.size       (req.size),
		.signed_ld  (req.signed_ld),
		.store_data (req.wdata),
		.bus_rdata  (32'h0000_0000),
		.lane_sel   (new_sel),
		.lane_wdata (new_wdata),
		.load_data  (),
		.misalign   (new_misalign)
	);

	wblm_lane_map u_act_map
	(
		.addr_lo    (req_q.addr[1:0]),
		.size       (req_q.size),
		.signed_ld  (req_q.signed_ld),
		.store_data (req_q.wdata),
		.bus_rdata  (act_rdata),
		.lane_sel   (),
		.lane_wdata (),
		.load_data  (act_load),
		.misalign   ()
	);

	// Watchdog runs while either strobe is high
	wire logic stb_active = mbus_q.stb | pbus_q.stb;
	wire logic timed_out;

	wblm_timeout u_tmo
	(
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.run      (stb_active),
		.expired  (timed_out)
	);

	// Address decode
	wire logic is_periph = (req.addr[31:24] == wblm_pkg::PERIPH_TOP_BYTE);
	wire logic take      = (state_q == wblm_pkg::ST_IDLE) && req_valid;
	wire logic launch    = take && !new_misalign;
	wire logic act_ack   = to_periph_q ? periph_ack_in : mem_ack_in;
	wire logic finish    = (state_q == wblm_pkg::ST_BUSY) &&
		(act_ack || timed_out);

	assign act_rdata = to_periph_q ? periph_rdata_in : mem_rdata_in;

	// Bus word built from the request; strobe and cycle rise with the
	// rest so address, data and selects are valid on the first edge
	wire wblm_pkg::wblm_bus_t launch_bus = '{
		addr:  {req.addr[31:2], 2'h0},
		wdata: new_wdata,
		sel:   new_sel,
		we:    req.write,
		stb:   1'b1,
		cyc:   1'b1
	};

	always_comb
	begin
		state_d = state_q;
		mbus_d  = mbus_q;
		pbus_d  = pbus_q;
		rsp_d   = rsp_q;
		case (state_q)
			wblm_pkg::ST_IDLE:
			begin
				if (take && new_misalign)
				begin
					// Misaligned: answer at once, nothing reaches the bus
					rsp_d   = '{rdata: 32'h0000_0000, timeout: 1'b0,
						misalign: 1'b1};
					state_d = wblm_pkg::ST_DONE;
				end
				else if (launch)
				begin
					if (is_periph)
						pbus_d = launch_bus;
					else
						mbus_d = launch_bus;
					state_d = wblm_pkg::ST_BUSY;
				end
			end
			wblm_pkg::ST_BUSY:
			begin
				if (finish)
				begin
					mbus_d.stb = 1'b0;
					mbus_d.cyc = 1'b0;
					pbus_d.stb = 1'b0;
					pbus_d.cyc = 1'b0;
					// Data captured only on a real acknowledge of a read
					rsp_d.rdata = (act_ack && !req_q.write) ?
						act_load : 32'h0000_0000;
					rsp_d.timeout  = !act_ack;
					rsp_d.misalign = 1'b0;
					state_d = wblm_pkg::ST_DONE;
				end
			end
			wblm_pkg::ST_DONE:
			begin
				state_d = wblm_pkg::ST_IDLE;
			end
			default:
			begin
				state_d = wblm_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q     <= wblm_pkg::ST_IDLE;
			req_q       <= '0;
			rsp_q       <= '0;
			mbus_q      <= '0;
			pbus_q      <= '0;
			to_periph_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			ready_q     <= 1'b0;
		end
		else
		begin
			state_q     <= state_d;
			rsp_q       <= rsp_d;
			mbus_q      <= mbus_d;
			pbus_q      <= pbus_d;
			rsp_valid_q <= (state_d == wblm_pkg::ST_DONE);
			ready_q     <= (state_d == wblm_pkg::ST_IDLE);
			if (take)
			begin
				req_q       <= req;
				to_periph_q <= is_periph;
			end
		end
	end

	// Core side
	assign req_ready = ready_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp       = rsp_q;

	// Memory port
	assign mem_addr_out     = mbus_q.addr;
	assign mem_wdata_out    = mbus_q.wdata;
	assign mem_lane_sel_out = mbus_q.sel;
	assign mem_we_out       = mbus_q.we;
	assign mem_strobe_out   = mbus_q.stb;
	assign mem_cycle_out    = mbus_q.cyc;

	// Peripheral port: only the low 24 address bits leave the block
	assign periph_addr_out     = pbus_q.addr[23:0];
	assign periph_wdata_out    = pbus_q.wdata;
	assign periph_lane_sel_out = pbus_q.sel;
	assign periph_we_out       = pbus_q.we;
	assign periph_strobe_out   = pbus_q.stb;
	assign periph_cycle_out    = pbus_q.cyc;

endmodule : wblm_master

// ---- verification/wblm_master_props.sv ----
// Checker: port-level properties of the load/store master
`timescale 1ns/1ps
module wblm_master_props
(
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst_n,
	// Core side
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic        rsp_valid,
	// Memory port
	input wire logic [31:0] mem_addr_out,
	input wire logic [3:0]  mem_lane_sel_out,
	input wire logic        mem_strobe_out,
	input wire logic        mem_cycle_out,
	input wire logic        mem_ack_in,
	// Peripheral port
	input wire logic        periph_strobe_out,
	input wire logic        periph_cycle_out,
	input wire logic        periph_ack_in
);
	localparam int TMO = 4096;
	logic [12:0] stb_cnt_q;
	wire         any_stb = mem_strobe_out || periph_strobe_out;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_mem_ack; mem_strobe_out && mem_ack_in; endsequence
	sequence s_io_ack; periph_strobe_out && periph_ack_in; endsequence
	// Counts how long a strobe has waited for its acknowledge
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			stb_cnt_q <= 13'h0;
		else
			stb_cnt_q <= any_stb ? stb_cnt_q + 13'h1 : 13'h0;
	a_mem_ack_end: assert property (s_mem_ack |=>
		!mem_strobe_out && !mem_cycle_out)
		else $error("mem strobe held after ack");
	a_io_ack_end: assert property (s_io_ack |=>
		!periph_strobe_out && !periph_cycle_out)
		else $error("periph strobe held after ack");
	a_rsp_after_ack: assert property (s_mem_ack |=> rsp_valid)
		else $error("no response after ack");
	a_io_rsp_ack: assert property (s_io_ack |=> rsp_valid)
		else $error("no response after periph ack");
	a_mem_stb_cyc: assert property (
		mem_strobe_out == mem_cycle_out)
		else $error("mem strobe and cycle differ");
	a_io_stb_cyc: assert property (
		periph_strobe_out == periph_cycle_out)
		else $error("periph strobe and cycle differ");
	a_mem_bus_hold: assert property (
		mem_strobe_out && !mem_ack_in |=> !mem_strobe_out ||
		$stable(mem_addr_out) && $stable(mem_lane_sel_out))
		else $error("mem bus moved in transfer");
	a_mem_lane_set: assert property (mem_strobe_out |->
		mem_lane_sel_out inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
		else $error("bad lane select");
	a_word_addr: assert property (mem_strobe_out |->
		mem_addr_out[1:0] == 2'h0)
		else $error("mem address not word aligned");
	a_one_port: assert property (
		!(mem_strobe_out && periph_strobe_out))
		else $error("both ports strobed");
	a_stall_bound: assert property (stb_cnt_q <= TMO)
		else $error("strobe outlived time-out");
	a_take_busy: assert property (req_valid && req_ready |=>
		!req_ready)
		else $error("ready during transfer");
	a_rsp_not_ready: assert property (rsp_valid |-> !req_ready)
		else $error("ready while response shown");
endmodule : wblm_master_props

bind wblm_master wblm_master_props u_props (.core_clk, .rst_n, .req_valid,
	.req_ready, .rsp_valid, .mem_addr_out, .mem_lane_sel_out, .mem_strobe_out,
	.mem_cycle_out, .mem_ack_in, .periph_strobe_out, .periph_cycle_out,
	.periph_ack_in);

// ---- verification/wblm_slave_model.sv ----
// Partner model: Wishbone slave memory with byte-lane writes
`timescale 1ns/1ps
module wblm_slave_model
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Bus from master
	input  wire logic [3:0]  word_idx,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  sel,
	input  wire logic        we,
	input  wire logic        stb,
	input  wire logic        cyc,
	// Behaviour controls
	input  wire logic [1:0]  wait_cyc,
	input  wire logic        mute,
	// Answer
	output logic             ack,
	output logic [31:0]      rdata
);
	logic [31:0] mem [16];
	logic [1:0]  cnt_q;
	wire         hit = stb && cyc && !ack && !mute;
	wire         go  = hit && cnt_q == wait_cyc;
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			ack   <= 1'b0;
			cnt_q <= 2'h0;
			rdata <= 32'h0;
		end
		else
		begin
			ack   <= go;
			cnt_q <= hit && !go ? cnt_q + 2'h1 : 2'h0;
			// Data outside the ack cycle toggles so stale reads show up
			rdata <= go ? mem[word_idx] : ~rdata;
			for (int i = 0; i < 4; i++)
				if (go && we && sel[i])
					mem[word_idx][8*i +: 8] <= wdata[8*i +: 8];
		end
endmodule : wblm_slave_model

// ---- verification/wblm_master_test.sv ----
// Testbench: random and corner load/store traffic on both ports
`timescale 1ns/1ps
module wblm_master_test;
	localparam logic [1:0] W = wblm_pkg::SIZE_WORD;
	localparam logic [1:0] H = wblm_pkg::SIZE_HALF;
	localparam logic [1:0] B = wblm_pkg::SIZE_BYTE;
	logic core_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, mute = 1'b0;
	logic [1:0] wait_cyc = 2'h0;
	wblm_pkg::wblm_req_t req = '0;
	wblm_pkg::wblm_rsp_t rsp;
	logic req_ready, rsp_valid, m_we, m_stb, m_cyc, m_ack;
	logic p_we, p_stb, p_cyc, p_ack;
	logic [31:0] m_addr, m_wd, m_rd, p_wd, p_rd, sh[2][16];
	logic [23:0] p_addr;
	logic [3:0] m_sel, p_sel;
	int num_errors = 0, compares = 0;
	integer seed = 32'h7f92;
	always #25 core_clk = ~core_clk;
	wblm_master DUT (.core_clk, .rst_n, .req_valid, .req, .req_ready,
		.rsp_valid, .rsp, .mem_addr_out(m_addr), .mem_wdata_out(m_wd),
		.mem_lane_sel_out(m_sel), .mem_we_out(m_we), .mem_strobe_out(m_stb),
		.mem_cycle_out(m_cyc), .mem_rdata_in(m_rd), .mem_ack_in(m_ack),
		.periph_addr_out(p_addr), .periph_wdata_out(p_wd),
		.periph_lane_sel_out(p_sel), .periph_we_out(p_we),
		.periph_strobe_out(p_stb), .periph_cycle_out(p_cyc),
		.periph_rdata_in(p_rd), .periph_ack_in(p_ack));
	wblm_slave_model u_mem (.core_clk, .rst_n, .word_idx(m_addr[5:2]),
		.wdata(m_wd), .sel(m_sel), .we(m_we), .stb(m_stb), .cyc(m_cyc),
		.wait_cyc, .mute, .ack(m_ack), .rdata(m_rd));
	wblm_slave_model u_io (.core_clk, .rst_n, .word_idx(p_addr[5:2]),
		.wdata(p_wd), .sel(p_sel), .we(p_we), .stb(p_stb), .cyc(p_cyc),
		.wait_cyc, .mute, .ack(p_ack), .rdata(p_rd));
	function automatic logic [3:0] e_sel(input logic [1:0] sz, lo);
		return sz == W ? 4'hF : (sz == H ? 4'h3 : 4'h1) << lo;
	endfunction : e_sel
	function automatic logic [31:0] e_ld(input logic [31:0] w,
		input logic [1:0] sz, lo, input logic sg);
		logic [31:0] s;
		s = w >> (8 * lo);
		if (sz == B)
			return {{24{sg & s[7]}}, s[7:0]};
		return sz == H ? {{16{sg & s[15]}}, s[15:0]} : w;
	endfunction : e_ld
	task automatic chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic do_req(input logic [31:0] a, wd, input logic [1:0] sz,
		input logic we, sg);
		for (int n = 0; n < 99 && req_ready !== 1'b1; n++)
			@(posedge core_clk);
		chk(req_ready, 1'b1);
		req_valid <= 1'b1;
		req <= '{a, wd, sz, we, sg};
		@(posedge core_clk);
		req_valid <= 1'b0;
		for (int n = 0; n < 5000 && rsp_valid !== 1'b1; n++)
			@(posedge core_clk);
		chk(rsp_valid, 1'b1);
	endtask : do_req
	task automatic op(input int p, input logic [3:0] i, input logic [1:0] lo,
		sz, input logic we, sg, input logic [31:0] wd);
		logic [31:0] a, s, wq;
		a = (p ? 32'hFF00_0000 : wblm_pkg::MEM_BASE) | {i, lo};
		s = sh[p][i];
		do_req(a, wd, sz, we, sg);
		wq = p ? p_wd : m_wd;
		chk(rsp.misalign, 1'b0);
		chk(p ? p_sel : m_sel, e_sel(sz, lo));
		chk(p ? {8'h00, p_addr} : m_addr,
			a & (p ? 32'hFF_FFFC : ~32'h3));
		chk(p ? p_we : m_we, we);
		for (int k = 0; k < 4; k++)
			if (we && ((e_sel(sz, lo) >> k) & 4'h1))
				chk(wq >> 8 * k & 32'hFF, (sz == W ? wd >> 8 * k :
					sz == H ? wd >> 8 * (k % 2) : wd) & 32'hFF);
		// Byte slave behind a 4:1 lane multiplexer picks the addressed lane
		if (p && we && sz == B)
			chk(wq >> 8 * lo & 32'hFF, {24'h0, wd[7:0]});
		if (we)
			sh[p][i] = sz == W ? wd : sz == H ? (lo[1] ?
				{wd[15:0], s[15:0]} : {s[31:16], wd[15:0]}) :
				(s & ~(32'hFF << 8 * lo)) | ({24'h0, wd[7:0]} << 8 * lo);
		else
			chk(rsp.rdata, e_ld(s, sz, lo, sg));
	endtask : op
	task give_verdict;
		$display("compares=%0d num_errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	initial
	begin
		#(50 * 60000);
		num_errors++;
		give_verdict();
	end
	initial
	begin
		logic [1:0] sz, lo;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		for (int c = 0; c < 24; c++)
		begin
			if (c % 12 == 0)
				op(c / 12, 4'h0, 2'h0, W, 1'b1, 1'b0, 32'hF07F_8001);
			op(c / 12, 4'h0, c % 12 < 8 ? c[1:0] : {c[0], 1'b0},
				c % 12 < 8 ? B : H, 1'b0, c % 12 < 8 ? c[2] : c[1], 32'h0);
		end
		$display("test sign corners done");
		for (int k = 0; k < 80; k++)
		begin
			wait_cyc <= $random(seed);
			sz = $unsigned($random(seed)) % 3;
			lo = $random(seed);
			lo = sz == W ? 2'h0 : sz == H ? lo & 2'h2 : lo;
			op(k % 2, k[4:1], 2'h0, W, 1'b1, 1'b0, $random(seed));
			op(k % 2, k[4:1], lo, sz, 1'b1, 1'b0, $random(seed));
			op(k % 2, k[4:1], lo, sz, 1'b0, $random(seed), 32'h0);
			op(k % 2, k[4:1], 2'h0, W, 1'b0, 1'b0, 32'h0);
		end
		$display("test random traffic done");
		do_req(wblm_pkg::MEM_BASE | 32'h2, 32'h0, W, 1'b0, 1'b0);
		chk(rsp.misalign, 1'b1);
		do_req(32'hFF00_0001, 32'h0, H, 1'b1, 1'b0);
		chk(rsp.misalign, 1'b1);
		mute <= 1'b1;
		do_req(wblm_pkg::MEM_BASE, 32'h0, W, 1'b0, 1'b0);
		chk(rsp.timeout, 1'b1);
		chk(rsp.rdata, 32'h0);
		mute <= 1'b0;
		$display("test refusals done");
		give_verdict();
	end
endmodule : wblm_master_test
